/* timer_cc_pkg.sv */
package timer_cc_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] CTRL_OFS = 8'h12;
  localparam logic [7:0] STATUS_OFS = 8'h13;
  localparam logic [7:0] CAP_HI_OFS = 8'h14;
  localparam logic [7:0] CAP_LO_OFS = 8'h15;
  localparam logic [7:0] CMP_HI_OFS = 8'h16;
  localparam logic [7:0] CMP_LO_OFS = 8'h17;
  localparam logic [7:0] CNT_HI_OFS = 8'h18;
  localparam logic [7:0] CNT_LO_OFS = 8'h19;

  // ****************************************************************
  // bit positions
  // ****************************************************************
  localparam int CAP_IE_BIT = 7;
  localparam int CMP_IE_BIT = 6;
  localparam int OVF_IE_BIT = 5;
  localparam int EDGE_SEL_BIT = 1;
  localparam int LEVEL_SEL_BIT = 0;
  localparam int CAP_FLAG_BIT = 7;
  localparam int CMP_FLAG_BIT = 6;
  localparam int OVF_FLAG_BIT = 5;

  // ****************************************************************
  // reset values and counter constants
  // ****************************************************************
  localparam logic [15:0] COUNT_RESET = 16'hfffc;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {T00, T01, T10, T11} timerState_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wrData;
    logic wrStb;
    logic rdStb;
  } busReq_t;

endpackage : timer_cc_pkg

/* timer_capture_compare_unit.sv */
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
module timer_capture_compare_unit (
  input wire logic clk,
  input wire logic rst_n,
  input wire timer_cc_pkg::busReq_t busReq,
  output logic [7:0] rdData,
  input wire logic stopMode,
  input wire logic waitMode,
  input wire logic captureInputPin,
  output logic compareOutputPin,
  output logic timerIrq
);
  import timer_cc_pkg::*;

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  timerState_t state_q, state_d;
  logic [15:0] count_q, count_d;
  logic [7:0] ctrl_q;
  logic capFlag_q, cmpFlag_q, ovfFlag_q;
  logic capArm_q, cmpArm_q, ovfArm_q;
  logic [7:0] capHi_q, capLo_q;
  logic [7:0] cmpHi_q, cmpLo_q;
  logic capLock_q, cmpInhibit_q, cmpMatch_q;
  logic capPend_q;
  logic [15:0] capSnap_q;
  logic stopArmed_q;
  logic [15:0] stopSnap_q;
  logic stopPrev_q, stopLatch_q, resetDone_q;
  logic [2:0] capSync_q;
  logic [2:0] capFill_q;
  logic levelOut_q, irq_q;
  logic [7:0] rdData_q;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  wire logic rdStatus = busReq.rdStb && hit(busReq.addr, STATUS_OFS);
  wire logic rdCapHi = busReq.rdStb && hit(busReq.addr, CAP_HI_OFS);
  wire logic rdCapLo = busReq.rdStb && hit(busReq.addr, CAP_LO_OFS);
  wire logic rdCntLo = busReq.rdStb && hit(busReq.addr, CNT_LO_OFS);
  wire logic wrCtrl = busReq.wrStb && hit(busReq.addr, CTRL_OFS);
  wire logic wrCmpHi = busReq.wrStb && hit(busReq.addr, CMP_HI_OFS);
  wire logic wrCmpLo = busReq.wrStb && hit(busReq.addr, CMP_LO_OFS);
  wire logic accCmpLo = wrCmpLo ||
                        (busReq.rdStb && hit(busReq.addr, CMP_LO_OFS));

  // ****************************************************************
  // timer state and counter
  // ****************************************************************
  // counter stops only in stop mode; wait leaves it running
  wire logic running = !stopMode;
  wire logic tickT10 = running && (state_q == T10);
  wire logic tickT01 = running && (state_q == T01);
  wire logic rollover = tickT10 && (count_q == COUNT_MAX);

  always_comb begin
    unique case (state_q)
      T00: state_d = T01;
      T01: state_d = T10;
      T10: state_d = T11;
      T11: state_d = T00;
    endcase
    if (!running) begin
      state_d = state_q;
    end
  end

  // one count per four bus clocks, stepped on entry to T11
  assign count_d = tickT10 ? count_q + COUNT_ONE : count_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= T00;
      count_q <= COUNT_RESET;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
    end
  end

  // ****************************************************************
  // control register
  // ****************************************************************
  // reset clears enables, edge select and level select
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= BYTE_ZERO;
    end else if (wrCtrl) begin
      ctrl_q <= busReq.wrData;
    end
  end

  wire logic capIe = ctrl_q[CAP_IE_BIT];
  wire logic cmpIe = ctrl_q[CMP_IE_BIT];
  wire logic ovfIe = ctrl_q[OVF_IE_BIT];
  wire logic edgeSel = ctrl_q[EDGE_SEL_BIT];
  wire logic levelSel = ctrl_q[LEVEL_SEL_BIT];

  // ****************************************************************
  // capture input synchronizer and edge detect
  // ****************************************************************
  // fill marks when stage three holds a real pin sample after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      capSync_q <= 3'h0;
      capFill_q <= 3'h0;
    end else begin
      capSync_q <= {capSync_q[1:0], captureInputPin};
      capFill_q <= {capFill_q[1:0], 1'b1};
    end
  end

  // stage two versus three; stage one feeds only stage two
  // no edge until the pipe is full, so a high pin cannot fake one at reset
  wire logic capEdge = capFill_q[2] &&
                       (edgeSel ? (capSync_q[1] && !capSync_q[2])
                                : (!capSync_q[1] && capSync_q[2]));

  // ****************************************************************
  // capture timing
  // ****************************************************************
  // counter plus one covers synchronizer latency
  wire logic [15:0] snapNow = capEdge ? count_q + COUNT_ONE
                                      : capSnap_q;
  wire logic pendNow = capPend_q || (running && capEdge);
  wire logic capEvent = tickT10 && pendNow;
  wire logic stopExit = stopPrev_q && !stopMode && resetDone_q;
  wire logic stopCapture = stopExit && stopArmed_q;
  wire logic capLoad = (capEvent || stopCapture) && !capLock_q;
  wire logic [15:0] capValue = stopCapture ? stopSnap_q : snapNow;
  wire logic capSet = capEvent || stopCapture;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      capPend_q <= 1'b0;
      capSnap_q <= 16'h0000;
      stopArmed_q <= 1'b0;
      stopSnap_q <= 16'h0000;
      stopPrev_q <= 1'b0;
      resetDone_q <= 1'b0;
    end else begin
      capPend_q <= pendNow && !tickT10;
      capSnap_q <= snapNow;
      stopPrev_q <= stopMode;
      resetDone_q <= 1'b1;
      if (stopExit) begin
        stopArmed_q <= 1'b0;
      end else if (stopMode && capEdge && !stopArmed_q) begin
        stopArmed_q <= 1'b1;
        stopSnap_q <= count_q + COUNT_ONE;
      end
    end
  end

  // ****************************************************************
  // capture register, kept through reset unless stop is high
  // ****************************************************************
  // stop level seen during reset tells a stop exit by reset
  always_ff @(posedge clk) begin
    stopLatch_q <= stopMode;
    if (!resetDone_q && stopLatch_q) begin
      capHi_q <= BYTE_ZERO;
      capLo_q <= BYTE_ZERO;
    end else if (capLoad) begin
      capHi_q <= capValue[15:8];
      capLo_q <= capValue[7:0];
    end
  end

  // high byte read blocks transfer until low byte read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      capLock_q <= 1'b0;
    end else if (rdCapLo) begin
      capLock_q <= 1'b0;
    end else if (rdCapHi) begin
      capLock_q <= 1'b1;
    end
  end

  // ****************************************************************
  // compare register, no reset
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (wrCmpHi) begin
      cmpHi_q <= busReq.wrData;
    end
    if (wrCmpLo) begin
      cmpLo_q <= busReq.wrData;
    end
  end

  // ****************************************************************
  // compare timing
  // ****************************************************************
  wire logic cmpHit = ({cmpHi_q, cmpLo_q} == count_q) && !cmpInhibit_q;
  wire logic cmpEvent = tickT10 && cmpMatch_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmpInhibit_q <= 1'b0;
      cmpMatch_q <= 1'b0;
      levelOut_q <= 1'b0;
    end else begin
      if (wrCmpLo) begin
        cmpInhibit_q <= 1'b0;
      end else if (wrCmpHi) begin
        cmpInhibit_q <= 1'b1;
      end
      if (tickT01) begin
        cmpMatch_q <= cmpHit;
      end else if (tickT10) begin
        cmpMatch_q <= 1'b0;
      end
      if (cmpEvent) begin
        levelOut_q <= levelSel;
      end
    end
  end

  // ****************************************************************
  // flags and two-step clearing
  // ****************************************************************
  // status read arms the flags then set; a set beats a clear
  wire logic capClr = rdCapLo && capArm_q;
  wire logic cmpClr = accCmpLo && cmpArm_q;
  wire logic ovfClr = rdCntLo && ovfArm_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      capFlag_q <= 1'b0;
      cmpFlag_q <= 1'b0;
      ovfFlag_q <= 1'b0;
      capArm_q <= 1'b0;
      cmpArm_q <= 1'b0;
      ovfArm_q <= 1'b0;
    end else begin
      capFlag_q <= capSet || (capFlag_q && !capClr);
      cmpFlag_q <= cmpEvent || (cmpFlag_q && !cmpClr);
      ovfFlag_q <= rollover || (ovfFlag_q && !ovfClr);
      capArm_q <= rdStatus ? capFlag_q : (capArm_q && !rdCapLo);
      cmpArm_q <= rdStatus ? cmpFlag_q : (cmpArm_q && !accCmpLo);
      ovfArm_q <= rdStatus ? ovfFlag_q : (ovfArm_q && !rdCntLo);
    end
  end

  // ****************************************************************
  // interrupt request
  // ****************************************************************
  wire logic irqNext = (capFlag_q && capIe) ||
                       (cmpFlag_q && cmpIe) ||
                       (ovfFlag_q && ovfIe);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irqNext;
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  wire logic [7:0] statusByte = {capFlag_q, cmpFlag_q, ovfFlag_q, 5'h00};
  logic [7:0] rdMux;

  always_comb begin
    unique case (busReq.addr)
      CTRL_OFS: rdMux = ctrl_q;
      STATUS_OFS: rdMux = statusByte;
      CAP_HI_OFS: rdMux = capHi_q;
      CAP_LO_OFS: rdMux = capLo_q;
      CMP_HI_OFS: rdMux = cmpHi_q;
      CMP_LO_OFS: rdMux = cmpLo_q;
      CNT_HI_OFS: rdMux = count_q[15:8];
      CNT_LO_OFS: rdMux = count_q[7:0];
      default: rdMux = BYTE_ZERO;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_q <= BYTE_ZERO;
    end else begin
      rdData_q <= busReq.rdStb ? rdMux : BYTE_ZERO;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign rdData = rdData_q;
  assign compareOutputPin = levelOut_q;
  assign timerIrq = irq_q;

  // wait needs no action of its own
  wire logic unusedWait = waitMode;

endmodule : timer_capture_compare_unit

/* timer_cc_chk.sv */
`timescale 1ns/1ps
module timer_cc_chk
  import timer_cc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire timer_cc_pkg::busReq_t busReq,
  input wire logic [7:0] rdData,
  input wire logic stopMode,
  input wire logic compareOutputPin,
  input wire logic timerIrq
);
  // ****************************************************************
  // shadow prescaler and counter
  // ****************************************************************
  logic [1:0] phase_q;
  logic [15:0] count_q;

  // steps the shadow counter when leaving T10, frozen in stop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= 2'h0;
      count_q <= COUNT_RESET;
    end else if (!stopMode) begin
      phase_q <= phase_q + 2'h1;
      if (phase_q == 2'h2) count_q <= count_q + 16'h0001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // bus steps reused by the properties
  sequence ctrlOffS;
    busReq.wrStb && busReq.addr == CTRL_OFS && busReq.wrData[7:5] == 3'h0;
  endsequence
  sequence stopLoRdS;
    busReq.rdStb && busReq.addr == CAP_LO_OFS && stopMode;
  endsequence
  property cmpKeepP;
    logic [7:0] a, d;
    (busReq.wrStb && busReq.addr[7:1] == 7'h0b, a = busReq.addr,
     d = busReq.wrData) ##2 (busReq.rdStb && busReq.addr == a)
    |=> rdData == d;
  endproperty
  property cntReadP;
    logic [7:0] v;
    (busReq.rdStb && busReq.addr == CNT_LO_OFS, v = count_q[7:0])
    |=> rdData == v;
  endproperty
  property stopCapP;
    logic [7:0] v;
    stopLoRdS ##1 (1'b1, v = rdData) ##1 stopLoRdS |=> rdData == v;
  endproperty

  rst_out_a: assert property ($rose(rst_n) |-> !timerIrq && !compareOutputPin)
    else $error("outputs not quiet after reset");
  stop_pin_a: assert property ($past(stopMode) |-> $stable(compareOutputPin))
    else $error("compare pin moved while stopped");
  stop_irq_a: assert property ($past(stopMode, 2) && $past(stopMode)
    && !$past(busReq.wrStb, 2) |-> !$rose(timerIrq))
    else $error("interrupt raised while stopped");
  pin_phase_a: assert property ($changed(compareOutputPin)
    |-> $past(phase_q) == 2'h2)
    else $error("compare pin moved outside T11 entry");
  cmp_keep_a: assert property (cmpKeepP)
    else $error("compare byte not read back");
  irq_gate_a: assert property (ctrlOffS |-> ##2 !timerIrq)
    else $error("interrupt with all enables off");
  cnt_read_a: assert property (cntReadP)
    else $error("counter low byte wrong");
  stop_cap_a: assert property (stopCapP)
    else $error("capture data changed during stop");
endmodule : timer_cc_chk

bind timer_capture_compare_unit timer_cc_chk u_chk (.clk(clk), .rst_n(rst_n),
  .busReq(busReq), .rdData(rdData), .stopMode(stopMode),
  .compareOutputPin(compareOutputPin), .timerIrq(timerIrq));

/* capture_source.sv */
`timescale 1ns/1ps
module capture_source (
  input wire logic clk,
  input wire logic loadPin,
  output logic pin,
  output logic [7:0] toggles
);
  // ****************************************************************
  // capture signal source and compare load
  // ****************************************************************
  initial pin = 1'b0;

  // edges land off the clock so the synchroniser sees an async input
  task automatic drive(input logic lvl);
    @(posedge clk);
    #3 pin = lvl;
  endtask : drive

  // load counts every level change on the compare pin
  initial begin
    toggles = 8'h00;
    forever @(loadPin) toggles = toggles + 8'h01;
  end
endmodule : capture_source

/* timer_capture_compare_unit_tb.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module timer_capture_compare_unit_tb;
  import timer_cc_pkg::*;
  // ****************************************************************
  // bench
  // ****************************************************************
  logic clk, rst_n, stopMode, waitMode, compareOutputPin, timerIrq, capPin;
  busReq_t busReq;
  logic [7:0] rdData, h, l, t0, cmpLo, toggles;
  logic [15:0] c, v;
  int miscompares, checks_done, cyc;

  timer_capture_compare_unit u_dut (.clk(clk), .rst_n(rst_n),
    .busReq(busReq), .rdData(rdData), .stopMode(stopMode),
    .waitMode(waitMode), .captureInputPin(capPin),
    .compareOutputPin(compareOutputPin), .timerIrq(timerIrq));
  capture_source u_src (.clk(clk), .loadPin(compareOutputPin), .pin(capPin),
    .toggles(toggles));

  // bus master, one strobe cycle per access
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    busReq <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    busReq.wrStb <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input int n, output logic [7:0] d);
    @(posedge clk);
    busReq <= '{a, 8'h00, 1'b0, 1'b1};
    repeat (n) @(posedge clk);
    busReq.rdStb <= 1'b0;
    #1 d = rdData;
  endtask : rd
  task automatic rdw(input logic [7:0] a, output logic [15:0] d);
    rd(a, 1, d[15:8]);
    rd(a + 8'h01, 1, d[7:0]);
  endtask : rdw
  task automatic mode(input logic s, input logic w);
    @(posedge clk);
    stopMode <= s;
    waitMode <= w;
  endtask : mode

  task automatic s_reset;
    rd(CTRL_OFS, 1, h); `CHK(h, 8'h00)
    rd(STATUS_OFS, 1, h); `CHK(h, 8'h00)
    rdw(CNT_HI_OFS, c); `CHK(c, 16'hfffc)
    rdw(CAP_HI_OFS, c); `CHK(c, 16'h0000)
  endtask : s_reset

  task automatic s_overflow;
    wr(CTRL_OFS, 8'h20);
    mode(1'b0, 1'b0);
    repeat (24) @(posedge clk);
    `CHK(timerIrq, 1'b1)
    rd(CNT_LO_OFS, 1, h);
    rd(STATUS_OFS, 1, h); `CHK(h[OVF_FLAG_BIT], 1'b1)
    rd(CNT_LO_OFS, 1, h);
    rd(STATUS_OFS, 1, h); `CHK(h[OVF_FLAG_BIT], 1'b0)
  endtask : s_overflow

  task automatic s_compare;
    mode(1'b1, 1'b1);
    rdw(CNT_HI_OFS, c);
    v = c + 16'h0003;
    t0 = toggles;
    wr(CMP_HI_OFS, v[15:8]);
    rd(CMP_HI_OFS, 1, h); `CHK(h, v[15:8])
    rd(STATUS_OFS, 1, h);
    wr(CMP_LO_OFS, v[7:0]);
    wr(CTRL_OFS, 8'h41);
    mode(1'b0, 1'b1);
    repeat (24) @(posedge clk);
    `CHK(compareOutputPin, 1'b1)
    `CHK(timerIrq, 1'b1)
    rd(STATUS_OFS, 1, h); `CHK(h[CMP_FLAG_BIT], 1'b1)
    mode(1'b1, 1'b1);
    rdw(CNT_HI_OFS, c);
    v = c + 16'h0003;
    wr(CMP_LO_OFS, v[7:0]);
    wr(CMP_HI_OFS, v[15:8]);
    wr(CTRL_OFS, 8'h40);
    mode(1'b0, 1'b1);
    repeat (24) @(posedge clk);
    `CHK(compareOutputPin, 1'b1)
    rd(STATUS_OFS, 1, h); `CHK(h[CMP_FLAG_BIT], 1'b0)
    mode(1'b1, 1'b0);
    rdw(CNT_HI_OFS, c);
    v = c + 16'h0003;
    cmpLo = v[7:0];
    wr(CMP_HI_OFS, v[15:8]);
    wr(CMP_LO_OFS, cmpLo);
    mode(1'b0, 1'b0);
    repeat (24) @(posedge clk);
    `CHK(compareOutputPin, 1'b0)
    `CHK(toggles - t0, 8'h02)
    rd(STATUS_OFS, 1, h); `CHK(h[CMP_FLAG_BIT], 1'b1)
    rd(CMP_LO_OFS, 1, h); `CHK(h, cmpLo)
    rd(STATUS_OFS, 1, h); `CHK(h[CMP_FLAG_BIT], 1'b0)
  endtask : s_compare

  task automatic s_capture;
    wr(CTRL_OFS, 8'h82);
    mode(1'b1, 1'b0);
    rdw(CNT_HI_OFS, c);
    u_src.drive(1'b1);
    repeat (12) @(posedge clk);
    rd(STATUS_OFS, 1, h); `CHK(h[CAP_FLAG_BIT], 1'b0)
    rd(CAP_LO_OFS, 1, h);
    rd(CAP_LO_OFS, 1, h);
    mode(1'b0, 1'b0);
    repeat (12) @(posedge clk);
    `CHK(timerIrq, 1'b1)
    rd(STATUS_OFS, 1, h); `CHK(h[CAP_FLAG_BIT], 1'b1)
    rdw(CAP_HI_OFS, v); `CHK(v, c + 16'h0001)
    rd(CAP_HI_OFS, 1, h);
    u_src.drive(1'b0);
    u_src.drive(1'b1);
    repeat (12) @(posedge clk);
    rd(STATUS_OFS, 1, h); `CHK(h[CAP_FLAG_BIT], 1'b1)
    rd(CAP_LO_OFS, 1, l); `CHK(l, v[7:0])
    u_src.drive(1'b0);
    u_src.drive(1'b1);
    repeat (12) @(posedge clk);
    rdw(CAP_HI_OFS, c); `CHK(c != v, 1'b1)
  endtask : s_capture

  task automatic s_edge;
    wr(CTRL_OFS, 8'h00);
    rd(STATUS_OFS, 1, h);
    rd(CAP_LO_OFS, 1, h);
    u_src.drive(1'b0);
    repeat (12) @(posedge clk);
    rd(STATUS_OFS, 1, h); `CHK(h[CAP_FLAG_BIT], 1'b1)
    `CHK(timerIrq, 1'b0)
    rd(CAP_LO_OFS, 1, h);
    u_src.drive(1'b1);
    repeat (12) @(posedge clk);
    rd(STATUS_OFS, 1, h); `CHK(h[CAP_FLAG_BIT], 1'b0)
  endtask : s_edge

  task automatic s_rereset;
    rdw(CAP_HI_OFS, v);
    wr(CTRL_OFS, 8'h03);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdw(CAP_HI_OFS, c); `CHK(c, v)
    rd(CMP_LO_OFS, 1, h); `CHK(h, cmpLo)
    rd(CTRL_OFS, 1, h); `CHK(h, 8'h00)
  endtask : s_rereset

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  // free running clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      conclude();
    end
  end

  // reset is held with stop high so capture bytes clear on release
  initial begin
    rst_n = 1'b0;
    stopMode = 1'b1;
    waitMode = 1'b0;
    busReq = '0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    s_reset();
    s_overflow();
    s_compare();
    s_capture();
    s_edge();
    s_rereset();
    conclude();
  end
endmodule : timer_capture_compare_unit_tb
